// ---- rtl/dprc_port_ctrl.sv ----
// Purpose: controller that drives one port of an asynchronous dual-port ram
// Assumes: one request at a time; device pins run through two-stage synchronisers
// Notes:   write pulse always at least one settle time long; no clock on the pins
`timescale 1ns/1ps
`include "dpram_defines.svh"
module dprc_port_ctrl
  import dprc_pkg::*;
(
  input  wire logic                       i_clock,        // 250 MHz system clock
  input  wire logic                       i_rst,          // async reset, active high
  input  wire logic                       i_req,          // start one access, pulse
  input  wire logic                       i_write,        // 1 write, 0 read
  input  wire logic                       i_token,        // 1 semaphore access, 0 array
  input  wire logic [`DPRC_ADDR_W-1:0]    i_addr,         // word or semaphore address
  input  wire logic [`DPRC_DATA_W-1:0]    i_wdata,        // write data
  input  wire logic [`DPRC_DATA_W-1:0]    i_pin_data,     // data pins as seen
  input  wire logic                       i_pin_busy_n,   // contention flag pin
  input  wire logic                       i_pin_int_n,    // mailbox flag pin
  output logic                            o_busy,         // access in progress
  output logic                            o_done,         // access finished, pulse
  output logic [`DPRC_DATA_W-1:0]         o_rdata,        // read data, held
  output logic                            o_token_held,   // last semaphore read saw zero
  output logic                            o_mail_n,       // synced mailbox flag
  output logic [`DPRC_ADDR_W-1:0]         o_pin_addr,     // address pins
  output logic                            o_pin_ce_n,     // chip select, low active
  output logic                            o_pin_sem_n,    // semaphore select, low active
  output logic                            o_pin_rw_n,     // read high, write low
  output logic                            o_pin_oe_n,     // output enable, low active
  output logic [`DPRC_DATA_W-1:0]         o_pin_data,     // data pins driven
  output logic                            o_pin_data_oe   // high while we drive data
);
  // cycle counts derived from the printed times
  localparam logic [`DPRC_CNT_W-1:0] PULSE_CYC = `DPRC_CNT_W'(
    `DPRC_CEIL_CYC((`DPRC_WRITE_PULSE_NS > `DPRC_OUT_OFF_NS + `DPRC_DATA_SETUP_NS) ?
      `DPRC_WRITE_PULSE_NS : `DPRC_OUT_OFF_NS + `DPRC_DATA_SETUP_NS));
  localparam logic [`DPRC_CNT_W-1:0] HOLD_CYC  = `DPRC_CNT_W'(`DPRC_CEIL_CYC(`DPRC_WRITE_HOLD_REL_NS));
  localparam logic [`DPRC_CNT_W-1:0] RELAX_CYC = `DPRC_CNT_W'(
    `DPRC_CEIL_CYC(`DPRC_FLAG_UPDATE_NS + `DPRC_TOKEN_W2R_NS));
  localparam logic [`DPRC_CNT_W-1:0] READ_CYC  = `DPRC_CNT_W'(`DPRC_CEIL_CYC(`DPRC_READ_ACCESS_NS) + 2);
  localparam logic [`DPRC_CNT_W-1:0] SETL_CYC  = `DPRC_CNT_W'(`DPRC_CEIL_CYC(`DPRC_FLAG_SETTLE_NS) + 2);

  dprc_state_t                  state_q;      // sequencer state
  logic [`DPRC_CNT_W-1:0]       cnt_q;        // cycles in current state
  logic                         wr_q;         // latched direction
  logic                         tok_q;        // latched target
  logic                         busy_seen_q;  // contention seen during pulse
  logic [1:0]                   busy_sync_q;  // contention flag synchroniser
  logic [1:0]                   int_sync_q;   // mailbox flag synchroniser
  logic [`DPRC_DATA_W-1:0]      d_sync1_q;    // data first stage
  logic [`DPRC_DATA_W-1:0]      d_sync2_q;    // data second stage
  logic                         busy_n;       // settled contention level

  assign busy_n = busy_sync_q[1];

  // pin synchronisers; first stages feed only the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      busy_sync_q <= 2'h3;
      int_sync_q  <= 2'h3;
      d_sync1_q   <= '0;
      d_sync2_q   <= '0;
    end else begin
      busy_sync_q <= {busy_sync_q[0], i_pin_busy_n};
      int_sync_q  <= {int_sync_q[0], i_pin_int_n};
      d_sync1_q   <= i_pin_data;
      d_sync2_q   <= d_sync1_q;
    end
  end

  // mailbox flag is set and cleared by the device at 3fff/3ffe; we only report it
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) o_mail_n <= 1'b1;
    else       o_mail_n <= int_sync_q[1];
  end

  // access sequencer
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q     <= DPRC_IDLE;
      cnt_q       <= '0;
      wr_q        <= 1'b0;
      tok_q       <= 1'b0;
      busy_seen_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + `DPRC_CNT_W'(1);
      unique case (state_q)
        DPRC_IDLE: begin
          cnt_q <= '0;
          if (i_req) begin
            wr_q  <= i_write;
            tok_q <= i_token;
            state_q <= DPRC_SETUP;
          end
        end
        // address settles with r/w high, select asserted
        DPRC_SETUP: begin
          cnt_q <= '0;
          busy_seen_q <= 1'b0;
          state_q <= wr_q ? DPRC_PULSE : DPRC_READ;
        end
        // write pulse: stretch while contention flag low, then hold after release
        DPRC_PULSE: begin
          if (!busy_n) begin
            busy_seen_q <= 1'b1;
            cnt_q <= '0;
          end else if ((busy_seen_q && cnt_q >= HOLD_CYC && cnt_q >= PULSE_CYC) ||
                       (!busy_seen_q && cnt_q >= SETL_CYC && cnt_q >= PULSE_CYC)) begin
            cnt_q <= '0;
            state_q <= tok_q ? DPRC_RELAX : DPRC_DONE;
          end
        end
        // semaphore: select off for flag update, then read back
        DPRC_RELAX: begin
          if (cnt_q >= RELAX_CYC) begin
            cnt_q <= '0;
            state_q <= DPRC_READ;
          end
        end
        DPRC_READ: begin
          if (cnt_q >= READ_CYC) begin
            cnt_q <= '0;
            state_q <= DPRC_DONE;
          end
        end
        DPRC_DONE: state_q <= DPRC_IDLE;
        default:   state_q <= DPRC_IDLE;
      endcase
    end
  end

  // pin drive; r/w only low inside the pulse, so address never moves mid-write
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pin_addr    <= '0;
      o_pin_ce_n    <= 1'b1;
      o_pin_sem_n   <= 1'b1;
      o_pin_rw_n    <= 1'b1;
      o_pin_oe_n    <= 1'b1;
      o_pin_data    <= '0;
      o_pin_data_oe <= 1'b0;
    end else begin
      if (state_q == DPRC_IDLE && i_req) begin
        o_pin_addr    <= i_addr;
        o_pin_data    <= i_wdata;
        o_pin_ce_n    <= i_token;
        o_pin_sem_n   <= !i_token;
        o_pin_data_oe <= i_write;
      end
      // r/w low only in the pulse, and never released while the flag is low
      o_pin_rw_n <= !(state_q == DPRC_SETUP && wr_q) && !(state_q == DPRC_PULSE &&
                    !(cnt_q >= PULSE_CYC && busy_n && (busy_seen_q ? cnt_q >= HOLD_CYC : cnt_q >= SETL_CYC)));
      o_pin_oe_n <= !((state_q == DPRC_SETUP && !wr_q) || (state_q == DPRC_RELAX && cnt_q >= RELAX_CYC) ||
                      (state_q == DPRC_READ && !(cnt_q >= READ_CYC)));
      // semaphore readback: let go of the data pins one cycle after r/w rose,
      // otherwise our own write data would fight the device during the read
      if (state_q == DPRC_RELAX) begin
        o_pin_data_oe <= 1'b0;
      end
      if (state_q == DPRC_RELAX && cnt_q < RELAX_CYC) begin
        o_pin_sem_n <= 1'b1;
      end else if (state_q == DPRC_RELAX) begin
        o_pin_sem_n <= 1'b0;
      end
      if (state_q == DPRC_DONE) begin
        o_pin_ce_n    <= 1'b1;
        o_pin_sem_n   <= 1'b1;
        o_pin_data_oe <= 1'b0;
      end
    end
  end

  // status and read capture
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_busy       <= 1'b0;
      o_done       <= 1'b0;
      o_rdata      <= '0;
      o_token_held <= 1'b0;
    end else begin
      o_busy <= (state_q != DPRC_IDLE) || i_req;
      o_done <= (state_q == DPRC_DONE);
      if (state_q == DPRC_READ && cnt_q >= READ_CYC) begin
        o_rdata <= d_sync2_q;
        if (tok_q) o_token_held <= !d_sync2_q[`DPRC_TOKEN_BIT];
      end
    end
  end
endmodule // dprc_port_ctrl

// ---- rtl/dpram_defines.svh ----
// Purpose: timing counts and field positions for the dual-port ram port controller
// Assumes: 250 MHz clock, 4 ns period
// Notes:   times are kept in ns and converted to cycles here
`ifndef DPRAM_DEFINES_SVH
`define DPRAM_DEFINES_SVH
`define DPRC_CLK_PERIOD_NS        4
// least times round up to whole cycles
`define DPRC_CEIL_CYC(ns)         (((ns) + `DPRC_CLK_PERIOD_NS - 1) / `DPRC_CLK_PERIOD_NS)
`define DPRC_WRITE_PULSE_NS       12
`define DPRC_OUT_OFF_NS           10
`define DPRC_DATA_SETUP_NS        10
`define DPRC_WRITE_HOLD_REL_NS    13
`define DPRC_FLAG_UPDATE_NS       10
`define DPRC_TOKEN_W2R_NS         5
`define DPRC_READ_ACCESS_NS       15
`define DPRC_FLAG_SETTLE_NS       15
`define DPRC_ADDR_W               14
`define DPRC_DATA_W               9
`define DPRC_TOKEN_IDX_W          3
`define DPRC_TOKEN_BIT            0
`define DPRC_CNT_W                4
`endif

// ---- rtl/dprc_pkg.sv ----
// Purpose: types for the dual-port ram port controller
// Assumes: nothing; timing counts and widths live in the defines header
// Notes:   states gray coded along the semaphore write path from idle to done
package dprc_pkg;
  typedef enum logic [2:0] {
    DPRC_IDLE   = 3'b000,
    DPRC_SETUP  = 3'b001,
    DPRC_PULSE  = 3'b011,
    DPRC_RELAX  = 3'b010,
    DPRC_READ   = 3'b110,
    DPRC_DONE   = 3'b111
  } dprc_state_t;
endpackage

// ---- tb/dprc_port_ctrl_properties.sv ----
// Purpose: pin timing checks for the port controller
// Assumes: 4 ns clock, widths from the shared defines
// Notes:   sees only the controller's ports
`timescale 1ns/1ps
`include "dpram_defines.svh"
module dprc_port_ctrl_properties (
  input wire logic                    i_clock,
  input wire logic                    i_rst,
  input wire logic                    i_pin_busy_n,
  input wire logic                    o_busy,
  input wire logic [`DPRC_ADDR_W-1:0] o_pin_addr,
  input wire logic                    o_pin_ce_n,
  input wire logic                    o_pin_sem_n,
  input wire logic                    o_pin_rw_n,
  input wire logic                    o_pin_oe_n,
  input wire logic [`DPRC_DATA_W-1:0] o_pin_data,
  input wire logic                    o_pin_data_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_ONE_SEL: assert property (o_pin_ce_n || o_pin_sem_n) else $error("both selects low");
  AST_WR_SEL: assert property (!o_pin_rw_n |-> !(o_pin_ce_n && o_pin_sem_n)) else $error("write unselected");
  AST_ADDR_STILL: assert property (!o_pin_rw_n |-> $stable(o_pin_addr)) else $error("addr moved in write");
  AST_PULSE: assert property ($fell(o_pin_rw_n) |-> !o_pin_rw_n [*5]) else $error("write pulse short");
  AST_DATA_HOLD: assert property ((!o_pin_rw_n || $rose(o_pin_rw_n)) |->
    o_pin_data_oe && $stable(o_pin_data)) else $error("write data moved");
  AST_REL_HOLD: assert property ($rose(i_pin_busy_n) && !o_pin_rw_n |-> !o_pin_rw_n [*4])
    else $error("write ended early");
  AST_STALL: assert property (!i_pin_busy_n && !$past(i_pin_busy_n) && !$past(i_pin_busy_n, 2) && !o_pin_rw_n
    |=> !o_pin_rw_n) else $error("write ended while flag low");
  AST_SEM_GAP: assert property ($rose(o_pin_rw_n) && !$past(o_pin_sem_n) |-> (o_pin_sem_n || o_pin_oe_n) [*3])
    else $error("semaphore readback too soon");
  AST_IDLE: assert property (!o_busy && !$past(o_busy) && !$past(o_busy, 2) |->
    o_pin_ce_n && o_pin_sem_n && o_pin_rw_n) else $error("pins active while idle");
endmodule // dprc_port_ctrl_properties
bind dprc_port_ctrl dprc_port_ctrl_properties chk (.i_clock(i_clock), .i_rst(i_rst), .i_pin_busy_n(i_pin_busy_n),
  .o_busy(o_busy), .o_pin_addr(o_pin_addr), .o_pin_ce_n(o_pin_ce_n), .o_pin_sem_n(o_pin_sem_n),
  .o_pin_rw_n(o_pin_rw_n), .o_pin_oe_n(o_pin_oe_n), .o_pin_data(o_pin_data), .o_pin_data_oe(o_pin_data_oe));

// ---- tb/dprc_ram_model.sv ----
// Purpose: behavioural dual-port ram seen from one port
// Assumes: far port driven by tasks of this model
// Notes:   released data pins show the inverse of the last read
`timescale 1ns/1ps
`include "dpram_defines.svh"
module dprc_ram_model (
  input  wire logic [`DPRC_ADDR_W-1:0] i_addr,
  input  wire logic                    i_ce_n,
  input  wire logic                    i_sem_n,
  input  wire logic                    i_rw_n,
  input  wire logic                    i_oe_n,
  input  wire logic [`DPRC_DATA_W-1:0] i_data,    // bus level
  input  wire logic                    i_contend, // far port owns the word
  output logic      [`DPRC_DATA_W-1:0] o_data,
  output logic                         o_busy_n,
  output logic                         o_int_n
);
  logic [8:0] mem [0:16383];
  logic [7:0] mine_q, far_q, pend_q; // semaphore owners and far waiter
  logic [8:0] last_q;
  realtime    rel_t;
  realtime    sem_t;             // end of the last semaphore write
  int         early_q;           // semaphore reads started too soon after a write
  logic       far_int_n;         // far port's mailbox flag
  wire        wr = (!i_ce_n || !i_sem_n) && !i_rw_n;
  wire        rd = (!i_ce_n || !i_sem_n) && i_rw_n && !i_oe_n;
  wire [8:0]  rv = i_sem_n ? mem[i_addr] : {9{~mine_q[i_addr[2:0]]}};
  assign o_data   = rd ? rv : ~last_q;
  assign o_busy_n = !i_contend;
  initial begin
    {mine_q, far_q, pend_q} = '0;
    last_q = '0;
    rel_t = 0;
    sem_t = 0;
    early_q = 0;
    far_int_n = 1'b1;
    o_int_n = 1'b1;
  end
  always @(posedge o_busy_n) rel_t = $realtime;
  // select-off gap plus write-to-read time must pass before a semaphore readback
  always @(posedge rd) if (!i_sem_n && ($realtime - sem_t) < 15.0) early_q++;
  // a write lands on whichever line ends it; a deferred write needs the release hold
  always @(negedge wr) begin
    if (!i_sem_n) begin
      if (i_data[0]) begin
        mine_q[i_addr[2:0]] = 1'b0;
        if (pend_q[i_addr[2:0]]) far_q[i_addr[2:0]] = 1'b1;
      end else if (!far_q[i_addr[2:0]]) mine_q[i_addr[2:0]] = 1'b1;
      sem_t = $realtime;
    end else if (o_busy_n && ($realtime - rel_t) >= 13.0) begin
      mem[i_addr] = i_data;
      if (i_addr == 14'h3fff) far_int_n = 1'b0;
    end
  end
  always @(negedge rd) begin
    last_q = rv;
    if (!i_ce_n && i_addr == 14'h3ffe) o_int_n = 1'b1;
  end
  task far_write(input logic [13:0] a, input logic [8:0] d);
    mem[a] = d;
    if (a == 14'h3ffe) o_int_n = 1'b0;
  endtask
  task far_sem(input logic [2:0] i, input logic b);
    if (b) far_q[i] = 1'b0;
    else if (mine_q[i]) pend_q[i] = 1'b1;
    else far_q[i] = 1'b1;
  endtask
endmodule // dprc_ram_model

// ---- tb/dprc_port_ctrl_bench.sv ----
// Purpose: self-checking bench for the port controller
// Assumes: inputs change on the falling clock edge
// Notes:   the far port is worked through model tasks
`timescale 1ns/1ps
`include "dpram_defines.svh"
module dprc_port_ctrl_bench;
  logic       clk, rst, req, wr, tok, contend;
  logic [13:0] addr;
  logic [8:0] wd;
  logic [8:0] rdata, pd, dd, bus;
  logic [13:0] pa;
  logic       busy, done, held, mail_n, ce_n, sem_n, rw_n, oe_n, doe, bsy_n, int_n;
  int         n_fail, checks_done;
  assign bus = doe ? pd : dd; // wire level from both drivers
  dprc_port_ctrl uut (.i_clock(clk), .i_rst(rst), .i_req(req), .i_write(wr), .i_token(tok), .i_addr(addr),
    .i_wdata(wd), .i_pin_data(bus), .i_pin_busy_n(bsy_n), .i_pin_int_n(int_n), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .o_token_held(held), .o_mail_n(mail_n), .o_pin_addr(pa), .o_pin_ce_n(ce_n),
    .o_pin_sem_n(sem_n), .o_pin_rw_n(rw_n), .o_pin_oe_n(oe_n), .o_pin_data(pd), .o_pin_data_oe(doe));
  dprc_ram_model dev (.i_addr(pa), .i_ce_n(ce_n), .i_sem_n(sem_n), .i_rw_n(rw_n), .i_oe_n(oe_n), .i_data(bus),
    .i_contend(contend), .o_data(dd), .o_busy_n(bsy_n), .o_int_n(int_n));
  task test_done;
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // one access, waiting a bounded time for completion
  task acc(input logic w, input logic t, input logic [13:0] a, input logic [8:0] d);
    int k;
    @(negedge clk);
    {req, wr, tok, addr, wd} = {1'b1, w, t, a, d};
    @(negedge clk);
    req = 1'b0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge clk);
    if (k == 300) begin
      n_fail++;
      test_done;
    end
  endtask
  task t_array;
    logic [13:0] a [3];
    a = '{14'h0000, 14'h1555, 14'h3fff};
    foreach (a[i]) acc(1, 0, a[i], a[i][8:0] ^ 9'h15a);
    foreach (a[i]) begin
      acc(0, 0, a[i], 9'h000);
      chk("array word", a[i][8:0] ^ 9'h15a, rdata);
    end
    chk("far mail", 9'h000, {8'h00, dev.far_int_n});
  endtask
  task t_far;
    dev.far_write(14'h0123, 9'h0c3);
    acc(0, 0, 14'h0123, 9'h000);
    chk("far word", 9'h0c3, rdata);
  endtask
  task t_stall;
    contend = 1'b1;
    fork
      acc(1, 0, 14'h0200, 9'h1e1);
      begin
        repeat (20) @(negedge clk);
        chk("stalled busy", 9'h001, {8'h00, busy});
        contend = 1'b0;
      end
    join
    acc(0, 0, 14'h0200, 9'h000);
    chk("deferred word", 9'h1e1, rdata);
  endtask
  task t_mail;
    dev.far_write(14'h3ffe, 9'h011);
    repeat (6) @(negedge clk);
    chk("mail set", 9'h000, {8'h00, mail_n});
    acc(0, 0, 14'h3ffe, 9'h000);
    repeat (6) @(negedge clk);
    chk("mail clear", 9'h001, {8'h00, mail_n});
  endtask
  task t_sem;
    acc(1, 1, 14'h0003, 9'h000);
    chk("token won", 9'h001, {8'h00, held});
    dev.far_sem(3'h3, 1'b0);
    acc(1, 1, 14'h0003, 9'h001);
    chk("token freed", 9'h000, {8'h00, held});
    acc(1, 1, 14'h000b, 9'h000);
    chk("token passed", 9'h000, {8'h00, held});
    acc(0, 1, 14'h0003, 9'h000);
    chk("token read", 9'h000, {8'h00, held});
    chk("early token read", 9'h000, dev.early_q[8:0]);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, req, wr, tok, contend, addr, wd} = {1'b1, 4'h0, 14'h0000, 9'h000};
    n_fail = 0;
    checks_done = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    chk("idle pins", 9'h01f, {4'h0, mail_n, ce_n, sem_n, rw_n, oe_n});
    t_array;
    t_far;
    t_stall;
    t_mail;
    t_sem;
    test_done;
  end
endmodule // dprc_port_ctrl_bench
